// [verilog/alu_exec_pkg.sv]
// Constants, opcodes and state layout for the execute block
package alu_exec_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// Register byte addresses
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_DST = 8'h04;
	localparam logic [7:0] REG_SRC = 8'h08;
	localparam logic [7:0] REG_IMM = 8'h0c;
	localparam logic [7:0] REG_FLAGS = 8'h10;
	localparam logic [7:0] REG_PC = 8'h14;
	localparam logic [7:0] REG_POINTER = 8'h18;
	localparam logic [7:0] REG_PAIR = 8'h1c;
	localparam logic [7:0] REG_TARGET = 8'h20;
	localparam logic [7:0] REG_STACK = 8'h24;
	localparam logic [7:0] REG_RESULT = 8'h28;
	localparam logic [7:0] REG_STATUS = 8'h2c;

	// Control word fields
	localparam int CTRL_OP_W = 6;
	localparam int CTRL_TWO_WORD_BIT = 8;
	localparam int CTRL_START_BIT = 31;

	// Flag register bit positions
	localparam int F_C = 0;
	localparam int F_Z = 1;
	localparam int F_N = 2;
	localparam int F_V = 3;
	localparam int F_S = 4;
	localparam int F_H = 5;
	localparam int F_T = 6;
	localparam int F_I = 7;

	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam logic [7:0] MASK_FULL = 8'hff;
	localparam logic [15:0] ONE_WORD = 16'h0001;
	localparam logic [15:0] SKIP_SHORT = 16'h0002;
	localparam logic [15:0] SKIP_LONG = 16'h0003;

	// Cycle counts
	localparam logic [2:0] CYCLES_SINGLE = 3'h1;
	localparam logic [2:0] CYCLES_WORD = 3'h2;
	localparam logic [2:0] CYCLES_MUL = 3'h2;
	localparam logic [2:0] CYCLES_JUMP = 3'h2;
	localparam logic [2:0] CYCLES_BRANCH = 3'h2;
	localparam logic [2:0] CYCLES_SKIP_SHORT = 3'h2;
	localparam logic [2:0] CYCLES_SKIP_LONG = 3'h3;
	localparam logic [2:0] CYCLES_CALL = 3'h3;
	localparam logic [2:0] CYCLES_ABS_CALL = 3'h4;
	localparam logic [2:0] CYCLES_RETURN = 3'h4;

	typedef enum logic [5:0] {
		add_regs = 6'h00, add_carry = 6'h01, word_plus_immediate = 6'h02, diff_regs = 6'h03,
		difference_immediate = 6'h04, difference_with_borrow = 6'h05,
		difference_immediate_borrow = 6'h06, word_minus_immediate = 6'h07, conj_regs = 6'h08,
		conjunction_immediate = 6'h09, disj_regs = 6'h0a, disj_immediate = 6'h0b,
		exclusive_disjunction = 6'h0c, invert_bits = 6'h0d, arith_inverse = 6'h0e,
		set_mask_bits = 6'h0f, clear_mask_bits = 6'h10, zero_minus_test = 6'h11,
		product_unsigned = 6'h12, product_signed = 6'h13, product_mixed_sign = 6'h14,
		fraction_product_unsigned = 6'h15, fraction_product_signed = 6'h16,
		fraction_product_mixed = 6'h17, relative_goto = 6'h18, pointer_goto = 6'h19,
		relative_call = 6'h1a, pointer_call = 6'h1b, absolute_call = 6'h1c, routine_exit = 6'h1d,
		interrupt_exit = 6'h1e, equal_then_skip = 6'h1f, compare_regs = 6'h20,
		compare_with_borrow = 6'h21, compare_immediate = 6'h22, skip_reg_bit_clear = 6'h23,
		skip_reg_bit_set = 6'h24, skip_io_bit_clear = 6'h25, skip_io_bit_set = 6'h26,
		branch_flag_set = 6'h27, branch_flag_clear = 6'h28, branch_signed_ge = 6'h29,
		branch_signed_lt = 6'h2a, branch_unsigned_ge = 6'h2b, branch_unsigned_lt = 6'h2c,
		branch_half_carry = 6'h2d, branch_half_clear = 6'h2e, branch_transfer_set = 6'h2f,
		branch_transfer_clear = 6'h30, branch_overflow = 6'h31, branch_no_overflow = 6'h32
	} op_type;

	typedef enum logic [1:0] {idle = 2'b01, run = 2'b10} phase_type;

	typedef struct packed {
		phase_type phase;
		logic [1:0] remaining;
		logic [2:0] last_cycles;
		logic [5:0] op;
		logic two_word;
		logic [7:0] dst;
		logic [7:0] src;
		logic [11:0] imm;
		logic [7:0] flags;
		logic [15:0] pc;
		logic [15:0] pointer;
		logic [15:0] pair;
		logic [15:0] target;
		logic [15:0] stack;
		logic [15:0] result;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} state_type;

	localparam state_type STATE_RESET = '{phase: idle, default: '0};
endpackage

// [verilog/alu_branch_execute.sv]
// Execute unit for arithmetic, logic, multiply, jump, skip and branch operations
`timescale 1ns/100ps
module alu_branch_execute (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [alu_exec_pkg::ADDR_W-1:0] paddr,
	input wire logic [alu_exec_pkg::DATA_W-1:0] pwdata,
	output logic [alu_exec_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr
);
	import alu_exec_pkg::*;

	state_type s;
	state_type n;
	op_type op;
	logic wr;
	logic launch;
	logic busy;
	logic cin;
	logic nv;
	logic two_word;
	logic cond;
	logic [2:0] cyc;
	logic [7:0] a;
	logic [7:0] imm8;
	logic [7:0] r8;
	logic [7:0] pa;
	logic [7:0] pb;
	logic [15:0] word_k;
	logic [15:0] w;
	logic [15:0] p16;
	logic [15:0] rel_off;
	logic [15:0] br_off;
	logic [15:0] pc_inc;
	logic [2:0] bit_sel;
	logic signed [17:0] prod;

	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;

	assign op = op_type'(pwdata[CTRL_OP_W-1:0]);
	assign two_word = pwdata[CTRL_TWO_WORD_BIT];
	assign busy = (s.phase == run);
	assign a = s.dst;
	assign imm8 = s.imm[7:0];
	assign cin = s.flags[F_C];
	assign nv = s.flags[F_N] ^ s.flags[F_V];
	assign bit_sel = s.imm[10:8];
	assign word_k = {10'h000, s.imm[5:0]};
	assign rel_off = {{4{s.imm[11]}}, s.imm};
	assign br_off = {{9{s.imm[6]}}, s.imm[6:0]};
	assign pc_inc = s.pc + ONE_WORD;
	assign wr = psel & penable & s.pready & pwrite & ~s.pslverr;
	assign launch = wr & (paddr == REG_CTRL) & pwdata[CTRL_START_BIT];

	// Sign extension per operand picks one multiplier for all six kinds
	assign pa = a;
	assign pb = s.src;
	always_comb begin
		logic sa;
		logic sb;
		sa = 1'b0;
		sb = 1'b0;
		sa = op inside {product_signed, product_mixed_sign, fraction_product_signed,
			fraction_product_mixed};
		sb = op inside {product_signed, fraction_product_signed};
		prod = $signed({sa & pa[7], pa}) * $signed({sb & pb[7], pb});
	end
	assign p16 = prod[15:0];

	function automatic logic [7:0] arith_flags(input logic [7:0] f, input logic [7:0] x,
		input logic [7:0] y, input logic [7:0] r, input logic sub, input logic chain);
		logic [7:0] o;
		logic h;
		logic v;
		logic c;
		o = f;
		if (sub) begin
			h = (~x[3] & y[3]) | (y[3] & r[3]) | (r[3] & ~x[3]);
			v = (x[7] & ~y[7] & ~r[7]) | (~x[7] & y[7] & r[7]);
			c = (~x[7] & y[7]) | (y[7] & r[7]) | (r[7] & ~x[7]);
		end else begin
			h = (x[3] & y[3]) | (y[3] & ~r[3]) | (~r[3] & x[3]);
			v = (x[7] & y[7] & ~r[7]) | (~x[7] & ~y[7] & r[7]);
			c = (x[7] & y[7]) | (y[7] & ~r[7]) | (~r[7] & x[7]);
		end
		o[F_H] = h;
		o[F_V] = v;
		o[F_C] = c;
		o[F_N] = r[7];
		// Chained zero lets multi-byte results report zero only if all bytes are
		o[F_Z] = (r == ZERO_BYTE) & (~chain | f[F_Z]);
		return o;
	endfunction

	function automatic logic [7:0] logic_flags(input logic [7:0] f, input logic [7:0] r);
		logic [7:0] o;
		o = f;
		o[F_Z] = (r == ZERO_BYTE);
		o[F_N] = r[7];
		o[F_V] = 1'b0;
		return o;
	endfunction

	always_comb begin
		n = s;
		r8 = a;
		w = s.pair;
		cond = 1'b0;
		cyc = CYCLES_SINGLE;
		n.pready = psel & ~penable;
		// Read data is captured in the setup cycle, one wait-free access follows
		if (psel & ~penable) begin
			n.pslverr = 1'b0;
			case (paddr)
				REG_CTRL: n.prdata = {23'h000000, s.two_word, 2'h0, s.op};
				REG_DST: n.prdata = {24'h000000, s.dst};
				REG_SRC: n.prdata = {24'h000000, s.src};
				REG_IMM: n.prdata = {20'h00000, s.imm};
				REG_FLAGS: n.prdata = {24'h000000, s.flags};
				REG_PC: n.prdata = {16'h0000, s.pc};
				REG_POINTER: n.prdata = {16'h0000, s.pointer};
				REG_PAIR: n.prdata = {16'h0000, s.pair};
				REG_TARGET: n.prdata = {16'h0000, s.target};
				REG_STACK: n.prdata = {16'h0000, s.stack};
				REG_RESULT: n.prdata = {16'h0000, s.result};
				REG_STATUS: n.prdata = {25'h0000000, s.last_cycles, 3'h0, busy};
				default: begin
					n.prdata = '0;
					n.pslverr = 1'b1;
				end
			endcase
			// A start while busy would lose the running count, so refuse it
			if (pwrite & (paddr == REG_CTRL) & pwdata[CTRL_START_BIT] & busy) begin
				n.pslverr = 1'b1;
			end
		end
		if (wr) begin
			case (paddr)
				REG_CTRL: begin
					n.op = pwdata[CTRL_OP_W-1:0];
					n.two_word = two_word;
				end
				REG_DST: n.dst = pwdata[7:0];
				REG_SRC: n.src = pwdata[7:0];
				REG_IMM: n.imm = pwdata[11:0];
				REG_FLAGS: n.flags = pwdata[7:0];
				REG_PC: n.pc = pwdata[15:0];
				REG_POINTER: n.pointer = pwdata[15:0];
				REG_PAIR: n.pair = pwdata[15:0];
				REG_TARGET: n.target = pwdata[15:0];
				REG_STACK: n.stack = pwdata[15:0];
				default: ;
			endcase
		end
		case (op)
			add_regs: r8 = a + s.src;
			add_carry: r8 = a + s.src + {7'h00, cin};
			diff_regs, compare_regs: r8 = a - s.src;
			difference_immediate, compare_immediate: r8 = a - imm8;
			difference_with_borrow, compare_with_borrow: r8 = a - s.src - {7'h00, cin};
			difference_immediate_borrow: r8 = a - imm8 - {7'h00, cin};
			conj_regs: r8 = a & s.src;
			conjunction_immediate: r8 = a & imm8;
			disj_regs: r8 = a | s.src;
			disj_immediate, set_mask_bits: r8 = a | imm8;
			exclusive_disjunction: r8 = a ^ s.src;
			invert_bits: r8 = MASK_FULL - a;
			arith_inverse: r8 = ZERO_BYTE - a;
			clear_mask_bits: r8 = a & (MASK_FULL - imm8);
			zero_minus_test: r8 = a & a;
			word_plus_immediate: w = s.pair + word_k;
			word_minus_immediate: w = s.pair - word_k;
			default: r8 = a;
		endcase
		case (op)
			equal_then_skip: cond = (a == s.src);
			skip_reg_bit_clear, skip_io_bit_clear: cond = ~s.src[bit_sel];
			skip_reg_bit_set, skip_io_bit_set: cond = s.src[bit_sel];
			branch_flag_set: cond = s.flags[bit_sel];
			branch_flag_clear: cond = ~s.flags[bit_sel];
			branch_signed_ge: cond = ~nv;
			branch_signed_lt: cond = nv;
			branch_unsigned_ge: cond = ~cin;
			branch_unsigned_lt: cond = cin;
			branch_half_carry: cond = s.flags[F_H];
			branch_half_clear: cond = ~s.flags[F_H];
			branch_transfer_set: cond = s.flags[F_T];
			branch_transfer_clear: cond = ~s.flags[F_T];
			branch_overflow: cond = s.flags[F_V];
			branch_no_overflow: cond = ~s.flags[F_V];
			default: cond = 1'b0;
		endcase
		case (s.phase)
			idle: begin
				if (launch) begin
					n.pc = pc_inc;
					case (op)
						add_regs, add_carry: begin
							n.dst = r8;
							n.flags = arith_flags(s.flags, a, s.src, r8, 1'b0, 1'b0);
						end
						diff_regs, difference_with_borrow: begin
							n.dst = r8;
							n.flags = arith_flags(s.flags, a, s.src, r8, 1'b1,
								op == difference_with_borrow);
						end
						difference_immediate, difference_immediate_borrow: begin
							n.dst = r8;
							n.flags = arith_flags(s.flags, a, imm8, r8, 1'b1,
								op == difference_immediate_borrow);
						end
						compare_regs, compare_with_borrow: begin
							n.flags = arith_flags(s.flags, a, s.src, r8, 1'b1,
								op == compare_with_borrow);
						end
						compare_immediate: n.flags = arith_flags(s.flags, a, imm8, r8, 1'b1, 1'b0);
						arith_inverse: begin
							n.dst = r8;
							n.flags = arith_flags(s.flags, ZERO_BYTE, a, r8, 1'b1, 1'b0);
						end
						conj_regs, conjunction_immediate, disj_regs, disj_immediate,
						exclusive_disjunction, set_mask_bits, clear_mask_bits,
						zero_minus_test: begin
							n.dst = r8;
							n.flags = logic_flags(s.flags, r8);
						end
						invert_bits: begin
							n.dst = r8;
							n.flags = logic_flags(s.flags, r8);
							n.flags[F_C] = 1'b1;
						end
						word_plus_immediate, word_minus_immediate: begin
							cyc = CYCLES_WORD;
							n.pair = w;
							n.flags[F_Z] = (w == 16'h0000);
							n.flags[F_N] = w[15];
							if (op == word_plus_immediate) begin
								n.flags[F_V] = ~s.pair[15] & w[15];
								n.flags[F_C] = ~w[15] & s.pair[15];
								n.flags[F_S] = w[15] ^ (~s.pair[15] & w[15]);
							end else begin
								n.flags[F_V] = s.pair[15] & ~w[15];
								n.flags[F_C] = w[15] & ~s.pair[15];
								n.flags[F_S] = w[15] ^ (s.pair[15] & ~w[15]);
							end
						end
						product_unsigned, product_signed, product_mixed_sign: begin
							cyc = CYCLES_MUL;
							n.result = p16;
							n.flags[F_C] = p16[15];
							n.flags[F_Z] = (p16 == 16'h0000);
						end
						fraction_product_unsigned, fraction_product_signed,
						fraction_product_mixed: begin
							cyc = CYCLES_MUL;
							n.result = {p16[14:0], 1'b0};
							n.flags[F_C] = p16[15];
							n.flags[F_Z] = ({p16[14:0], 1'b0} == 16'h0000);
						end
						relative_goto: begin
							cyc = CYCLES_JUMP;
							n.pc = pc_inc + rel_off;
						end
						pointer_goto: begin
							cyc = CYCLES_JUMP;
							n.pc = s.pointer;
						end
						relative_call, pointer_call, absolute_call: begin
							n.stack = pc_inc;
							cyc = (op == absolute_call) ? CYCLES_ABS_CALL : CYCLES_CALL;
							if (op == relative_call) begin
								n.pc = pc_inc + rel_off;
							end else if (op == pointer_call) begin
								n.pc = s.pointer;
							end else begin
								n.pc = s.target;
							end
						end
						routine_exit, interrupt_exit: begin
							cyc = CYCLES_RETURN;
							n.pc = s.stack;
							if (op == interrupt_exit) begin
								n.flags[F_I] = 1'b1;
							end
						end
						equal_then_skip, skip_reg_bit_clear, skip_reg_bit_set,
						skip_io_bit_clear, skip_io_bit_set: begin
							if (cond) begin
								n.pc = s.pc + (two_word ? SKIP_LONG : SKIP_SHORT);
								cyc = two_word ? CYCLES_SKIP_LONG : CYCLES_SKIP_SHORT;
							end
						end
						branch_flag_set, branch_flag_clear, branch_signed_ge, branch_signed_lt,
						branch_unsigned_ge, branch_unsigned_lt, branch_half_carry,
						branch_half_clear, branch_transfer_set, branch_transfer_clear,
						branch_overflow, branch_no_overflow: begin
							if (cond) begin
								n.pc = pc_inc + br_off;
								cyc = CYCLES_BRANCH;
							end
						end
						default: ;
					endcase
					n.last_cycles = cyc;
					n.remaining = 2'(cyc - CYCLES_SINGLE);
					n.phase = (cyc > CYCLES_SINGLE) ? run : idle;
				end
			end
			// Results are visible at once; busy only models the cycle cost
			run: begin
				n.remaining = s.remaining - 2'h1;
				if (s.remaining == 2'h1) begin
					n.phase = idle;
				end
			end
			default: n.phase = idle;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= STATE_RESET;
		end else begin
			s <= n;
		end
	end

	property p_add;
		@(posedge pclk) disable iff (!presetn)
		launch && op == add_regs |=> s.dst == 8'($past(a) + $past(s.src)) && s.phase == idle;
	endproperty
	a_add: assert property (p_add) else $error("add result wrong");

	property p_word;
		@(posedge pclk) disable iff (!presetn)
		launch && op == word_plus_immediate |=>
			s.pair == 16'($past(s.pair) + $past(word_k)) && s.phase == run ##1 s.phase == idle;
	endproperty
	a_word: assert property (p_word) else $error("word add wrong");

	property p_sub;
		@(posedge pclk) disable iff (!presetn)
		launch && op == diff_regs |=> s.dst == 8'($past(a) - $past(s.src));
	endproperty
	a_sub: assert property (p_sub) else $error("difference wrong");

	property p_logic_carry;
		@(posedge pclk) disable iff (!presetn)
		launch && op inside {conj_regs, disj_regs, exclusive_disjunction} |=>
			s.flags[F_C] == $past(cin) && !s.flags[F_V];
	endproperty
	a_logic_carry: assert property (p_logic_carry) else $error("logic flags wrong");

	property p_clear_mask;
		@(posedge pclk) disable iff (!presetn)
		launch && op == clear_mask_bits |=> s.dst == ($past(a) & ~$past(imm8));
	endproperty
	a_clear_mask: assert property (p_clear_mask) else $error("mask clear wrong");

	property p_product;
		@(posedge pclk) disable iff (!presetn)
		launch && op == fraction_product_unsigned |=>
			s.result == 16'((16'($past(a)) * 16'($past(s.src))) << 1) ##1 s.phase == idle;
	endproperty
	a_product: assert property (p_product) else $error("fraction product wrong");

	property p_rel_goto;
		@(posedge pclk) disable iff (!presetn)
		launch && op == relative_goto |=>
			s.pc == 16'($past(s.pc) + $past(rel_off) + ONE_WORD) && s.phase == run;
	endproperty
	a_rel_goto: assert property (p_rel_goto) else $error("relative goto wrong");

	property p_call;
		@(posedge pclk) disable iff (!presetn)
		launch && op == pointer_call |=> s.pc == $past(s.pointer) && s.phase == run
			##1 s.phase == run ##1 s.phase == idle;
	endproperty
	a_call: assert property (p_call) else $error("pointer call wrong");

	property p_skip;
		@(posedge pclk) disable iff (!presetn)
		launch && op == equal_then_skip && a == s.src && !two_word |=>
			s.pc == 16'($past(s.pc) + SKIP_SHORT) && s.last_cycles == CYCLES_SKIP_SHORT;
	endproperty
	a_skip: assert property (p_skip) else $error("skip wrong");

	property p_compare;
		@(posedge pclk) disable iff (!presetn)
		launch && op == compare_regs |=>
			s.dst == $past(a) && s.flags[F_Z] == ($past(a) == $past(s.src));
	endproperty
	a_compare: assert property (p_compare) else $error("compare wrong");

	property p_signed_ge;
		@(posedge pclk) disable iff (!presetn)
		launch && op == branch_signed_ge |=> s.pc == ($past(nv) ? $past(pc_inc) :
			16'($past(pc_inc) + $past(br_off)));
	endproperty
	a_signed_ge: assert property (p_signed_ge) else $error("signed branch wrong");
endmodule // alu_branch_execute

// [tb/tb.sv]
// Self-checking testbench for the execute block
`timescale 1ns/100ps
module tb;
	import alu_exec_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e, tw, t, sk;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata, q;
	logic [7:0] d, s, f, k, g;
	logic [15:0] pc, p, x, y;
	logic [2:0] b, cyc;
	int miscompares = 0;
	int num_checks = 0;
	int ia, ib;
	integer seed = 32'h1236da2e;
	op_type op;
	op_type alu_ops[19] = '{add_regs, add_carry, diff_regs, difference_immediate,
		difference_with_borrow, difference_immediate_borrow, conj_regs, conjunction_immediate,
		disj_regs, disj_immediate, exclusive_disjunction, invert_bits, arith_inverse,
		set_mask_bits, clear_mask_bits, zero_minus_test, compare_regs, compare_with_borrow,
		compare_immediate};
	op_type mul_ops[6] = '{product_unsigned, product_signed, product_mixed_sign,
		fraction_product_unsigned, fraction_product_signed, fraction_product_mixed};

	alu_branch_execute alu_branch_execute_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));

	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Request held until pready is seen at a falling edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		// Ready looked at mid-cycle, where it has settled
		do begin
			@(negedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16) begin
			miscompares++;
			summarize();
		end
		@(posedge pclk);
		// Read data and error only reload in a setup cycle, so they stand here
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] wd);
		apb(1'b1, a, wd);
	endtask

	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
	endtask

	task automatic setup(input logic [7:0] dv, sv, fv, input logic [11:0] iv,
		input logic [15:0] pv);
		wr(REG_DST, 32'(dv));
		wr(REG_SRC, 32'(sv));
		wr(REG_IMM, 32'(iv));
		wr(REG_FLAGS, 32'(fv));
		wr(REG_PC, 32'(pv));
	endtask

	task automatic start(input op_type o, input logic w2);
		wr(REG_CTRL, {1'b1, 22'h000000, w2, 2'h0, 6'(o)});
	endtask

	// Polls busy; cycle count of the op read back once idle
	task automatic wait_idle(input logic [2:0] n);
		int i;
		i = 0;
		do begin
			rd(REG_STATUS);
			i++;
		end while (q[0] !== 1'b0 && i < 8);
		if (q[0] !== 1'b0) begin
			miscompares++;
			summarize();
		end
		chk(32'(q[6:4]), 32'(n));
	endtask

	task automatic go(input op_type o, input logic w2, input logic [2:0] n);
		start(o, w2);
		chk(32'(e), 32'h0);
		wait_idle(n);
	endtask

	// Returns {flags, result}; S untouched by byte ops
	function automatic logic [15:0] ref_alu(input op_type o, input logic [7:0] a, bb, fl);
		logic [8:0] r;
		logic [7:0] fo;
		logic [7:0] xa;
		logic cin, sub, ch, ar;
		fo = fl;
		xa = a;
		ch = o inside {difference_with_borrow, difference_immediate_borrow, compare_with_borrow};
		cin = (ch || o == add_carry) ? fl[F_C] : 1'b0;
		sub = ch || o inside {diff_regs, difference_immediate, compare_regs, compare_immediate,
			arith_inverse};
		ar = sub || o inside {add_regs, add_carry};
		// Negation is zero minus the register
		if (o == arith_inverse) begin
			xa = 8'h00;
			bb = a;
		end
		case (o)
			conj_regs, conjunction_immediate: r = {1'b0, a & bb};
			disj_regs, disj_immediate, set_mask_bits: r = {1'b0, a | bb};
			exclusive_disjunction: r = {1'b0, a ^ bb};
			clear_mask_bits: r = {1'b0, a & (8'hff - bb)};
			zero_minus_test: r = {1'b0, a & a};
			invert_bits: r = {1'b0, 8'hff - a};
			default: r = sub ? {1'b0, xa} - {1'b0, bb} - cin : {1'b0, xa} + {1'b0, bb} + cin;
		endcase
		fo[F_N] = r[7];
		fo[F_Z] = (r[7:0] == 8'h00) && (!ch || fl[F_Z]);
		fo[F_V] = 1'b0;
		if (o == invert_bits)
			fo[F_C] = 1'b1;
		if (ar) begin
			fo[F_C] = r[8];
			fo[F_V] = sub ? (xa[7] & ~bb[7] & ~r[7]) | (~xa[7] & bb[7] & r[7]) :
				(xa[7] & bb[7] & ~r[7]) | (~xa[7] & ~bb[7] & r[7]);
			fo[F_H] = sub ? (~xa[3] & bb[3]) | (bb[3] & r[3]) | (r[3] & ~xa[3]) :
				(xa[3] & bb[3]) | (bb[3] & ~r[3]) | (~r[3] & xa[3]);
		end
		return {fo, r[7:0]};
	endfunction

	function automatic logic taken(input op_type o, input logic [7:0] fl, input logic [2:0] bs);
		case (o)
			branch_flag_set, skip_reg_bit_set, skip_io_bit_set: return fl[bs];
			branch_flag_clear, skip_reg_bit_clear, skip_io_bit_clear: return ~fl[bs];
			branch_signed_ge: return ~(fl[F_N] ^ fl[F_V]);
			branch_signed_lt: return fl[F_N] ^ fl[F_V];
			branch_unsigned_ge: return ~fl[F_C];
			branch_unsigned_lt: return fl[F_C];
			branch_half_carry: return fl[F_H];
			branch_half_clear: return ~fl[F_H];
			branch_transfer_set: return fl[F_T];
			branch_transfer_clear: return ~fl[F_T];
			branch_overflow: return fl[F_V];
			default: return ~fl[F_V];
		endcase
	endfunction

	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		rd(REG_DST);
		chk(q, 32'h0);
		rd(8'h30);
		chk(32'(e), 32'h1);
		chk(q, 32'h0);
		wr(REG_RESULT, 32'h0000ffff);
		rd(REG_RESULT);
		chk(q, 32'h0);
		$display("test registers done");
		for (int i = 0; i < 38; i++) begin
			op = alu_ops[i % 19];
			d = 8'($random(seed));
			s = 8'($random(seed));
			f = 8'($random(seed));
			k = 8'($random(seed));
			pc = 16'($random(seed));
			sk = op inside {difference_immediate, difference_immediate_borrow,
				conjunction_immediate, disj_immediate, set_mask_bits, clear_mask_bits,
				compare_immediate};
			t = op inside {compare_regs, compare_with_borrow, compare_immediate};
			x = ref_alu(op, d, sk ? k : s, f);
			setup(d, s, f, {4'h0, k}, pc);
			go(op, 1'b0, CYCLES_SINGLE);
			rd(REG_DST);
			chk(q, 32'(t ? d : x[7:0]));
			rd(REG_FLAGS);
			chk(q, 32'(x[15:8]));
			rd(REG_PC);
			chk(q, 32'(16'(pc + 16'h0001)));
		end
		$display("test arithmetic and logic done");
		for (int i = 0; i < 8; i++) begin
			op = i[0] ? word_minus_immediate : word_plus_immediate;
			p = 16'($random(seed));
			k = {2'b00, 6'($random(seed))};
			f = 8'($random(seed));
			ia = i[0] ? $signed(p) - int'(k) : $signed(p) + int'(k);
			ib = i[0] ? int'(p) - int'(k) : int'(p) + int'(k);
			x = 16'(ib);
			g = f;
			g[F_C] = ib < 0 || ib > 65535;
			g[F_Z] = x == 16'h0000;
			g[F_N] = x[15];
			g[F_V] = ia < -32768 || ia > 32767;
			g[F_S] = x[15] ^ g[F_V];
			setup(8'h00, 8'h00, f, {6'h00, k[5:0]}, 16'h0000);
			wr(REG_PAIR, 32'(p));
			go(op, 1'b0, CYCLES_WORD);
			rd(REG_PAIR);
			chk(q, 32'(x));
			rd(REG_FLAGS);
			chk(q, 32'(g));
		end
		$display("test word arithmetic done");
		for (int i = 0; i < 12; i++) begin
			d = 8'($random(seed));
			s = 8'($random(seed));
			ia = (i % 3 != 0) ? int'($signed(d)) : int'(d);
			ib = (i % 3 == 1) ? int'($signed(s)) : int'(s);
			p = 16'(ia * ib);
			x = (i % 6 >= 3) ? p << 1 : p;
			setup(d, s, 8'h00, 12'h000, 16'h0000);
			go(mul_ops[i % 6], 1'b0, CYCLES_MUL);
			rd(REG_RESULT);
			chk(q, 32'(x));
			rd(REG_FLAGS);
			chk(q, 32'({x == 16'h0000, p[15]}));
		end
		$display("test multiply done");
		for (int r = 0; r < 3; r++) begin
			for (int c = 31; c <= 50; c++) begin
				if (c >= 32 && c <= 34)
					continue;
				op = op_type'(c);
				sk = c < 39;
				d = 8'($random(seed));
				s = r[0] ? d : 8'($random(seed));
				f = 8'($random(seed));
				k = 8'($random(seed));
				b = 3'($random(seed));
				tw = sk & 1'($random(seed));
				pc = 16'($random(seed));
				t = (op == equal_then_skip) ? d == s : taken(op, sk ? s : f, b);
				cyc = !t ? 3'h1 : (sk ? (tw ? 3'h3 : 3'h2) : 3'h2);
				x = pc + (!t ? 16'h1 : (sk ? 16'(cyc) : 16'h1 + {{9{k[6]}}, k[6:0]}));
				setup(d, s, f, {1'b0, b, 1'b0, k[6:0]}, pc);
				go(op, tw, cyc);
				rd(REG_PC);
				chk(q, 32'(x));
				rd(REG_FLAGS);
				chk(q, 32'(f));
			end
		end
		$display("test skip and branch done");
		pc = 16'($random(seed));
		setup(8'h00, 8'h00, 8'h00, 12'h800, pc);
		go(relative_goto, 1'b0, CYCLES_JUMP);
		rd(REG_PC);
		chk(q, 32'(16'(pc + 16'hf801)));
		pc = 16'($random(seed));
		x = 16'($random(seed));
		setup(8'h00, 8'h00, 8'h00, 12'h000, pc);
		wr(REG_TARGET, 32'(x));
		start(absolute_call, 1'b0);
		start(relative_goto, 1'b0);
		chk(32'(e), 32'h1);
		wait_idle(CYCLES_ABS_CALL);
		rd(REG_PC);
		chk(q, 32'(x));
		rd(REG_STACK);
		chk(q, 32'(16'(pc + 16'h0001)));
		go(interrupt_exit, 1'b0, CYCLES_RETURN);
		rd(REG_PC);
		chk(q, 32'(16'(pc + 16'h0001)));
		rd(REG_FLAGS);
		chk(q, 32'h80);
		for (int i = 0; i < 12; i++) begin
			op = op_type'(6'h18 + 6'(i % 6));
			pc = 16'($random(seed));
			p = 16'($random(seed));
			x = 16'($random(seed));
			ia = $random(seed);
			setup(8'h00, 8'h00, 8'h00, ia[11:0], pc);
			wr(REG_POINTER, 32'(p));
			wr(REG_TARGET, 32'(x));
			wr(REG_STACK, 32'(p ^ x));
			case (i % 6)
				0, 2: y = pc + 16'h0001 + {{4{ia[11]}}, ia[11:0]};
				1, 3: y = p;
				4: y = x;
				default: y = p ^ x;
			endcase
			go(op, 1'b0, 3'(2 + (i % 6) / 2));
			rd(REG_PC);
			chk(q, 32'(y));
			rd(REG_STACK);
			chk(q, 32'((i % 6 >= 2 && i % 6 <= 4) ? 16'(pc + 16'h0001) : 16'(p ^ x)));
			rd(REG_FLAGS);
			chk(q, 32'h0);
		end
		$display("test jump call return done");
		summarize();
	end
endmodule // tb
